// [hw/tpio_cfg.svh]
// Register offsets, field masks and reset values for the two-port pin block
`ifndef TPIO_CFG_SVH
`define TPIO_CFG_SVH
`define TPIO_OFF_A_DIR 12'hE00
`define TPIO_OFF_A_LVL 12'hE02
`define TPIO_OFF_A_LAT 12'hE04
`define TPIO_OFF_A_ODS 12'hE06
`define TPIO_OFF_A_CNE 12'hE08
`define TPIO_OFF_A_PU 12'hE0A
`define TPIO_OFF_A_PD 12'hE0C
`define TPIO_OFF_A_ANS 12'hE0E
`define TPIO_OFF_B_DIR 12'hE10
`define TPIO_OFF_B_LVL 12'hE12
`define TPIO_OFF_B_LAT 12'hE14
`define TPIO_OFF_B_ODS 12'hE16
`define TPIO_OFF_B_CNE 12'hE18
`define TPIO_OFF_B_PU 12'hE1A
`define TPIO_OFF_B_PD 12'hE1C
`define TPIO_OFF_B_ANS 12'hE1E
`define TPIO_OFF_IRQ_STAT 12'hE20
`define TPIO_OFF_IRQ_MASK 12'hE22
`define TPIO_MASK_A 16'h001F
`define TPIO_MASK_B 16'hFFFF
`define TPIO_ANS_MASK_A 16'h0007
`define TPIO_ANS_MASK_B 16'h06FF
`define TPIO_RST_DIR_A 16'h001F
`define TPIO_RST_DIR_B 16'hFFFF
`define TPIO_RST_ANS_A 16'h0007
`define TPIO_RST_ANS_B 16'h06FF
`define TPIO_RST_ZERO 16'h0000
`define TPIO_CN_IRQ_NUM 8'h13
`define TPIO_CN_FLAG_BIT 3
`endif

// [hw/tpio_pkg.sv]
// Types shared by the two-port pin block
package tpio_pkg;
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] ods;
    logic [15:0] cne;
    logic [15:0] pu;
    logic [15:0] pd;
    logic [15:0] ans;
  } tpio_port_t;
  typedef struct packed {
    tpio_port_t a;
    tpio_port_t b;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [15:0] sync1_a;
    logic [15:0] sync2_a;
    logic [15:0] prev_a;
    logic [15:0] sync1_b;
    logic [15:0] sync2_b;
    logic [15:0] prev_b;
    logic pready;
    logic [31:0] prdata;
    logic irq;
    logic [15:0] a_out;
    logic [15:0] a_oe;
    logic [15:0] b_out;
    logic [15:0] b_oe;
    logic [15:0] ana_a;
    logic [15:0] ana_b;
  } tpio_state_t;
endpackage : tpio_pkg

// [hw/tpio_top.sv]
// Two-port general purpose pin block with APB register access
`timescale 1ns/10ps
`include "tpio_cfg.svh"
module tpio_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [4:0] PORT_A_IN,
  output logic [4:0] PORT_A_OUT,
  output logic [4:0] PORT_A_OE,
  output logic [4:0] PORT_A_PULLUP,
  output logic [4:0] PORT_A_PULLDOWN,
  output logic [4:0] PORT_A_ANALOG,
  input wire logic [15:0] PORT_B_IN,
  output logic [15:0] PORT_B_OUT,
  output logic [15:0] PORT_B_OE,
  output logic [15:0] PORT_B_PULLUP,
  output logic [15:0] PORT_B_PULLDOWN,
  output logic [15:0] PORT_B_ANALOG,
  output logic CHANGE_IRQ
);

  tpio_pkg::tpio_state_t s;
  tpio_pkg::tpio_state_t next_s;

  // Implemented pins and analog-select positions per port
  localparam logic [15:0] msk_a = `TPIO_MASK_A;
  localparam logic [15:0] msk_b = `TPIO_MASK_B;
  localparam logic [15:0] amsk_a = `TPIO_ANS_MASK_A;
  localparam logic [15:0] amsk_b = `TPIO_ANS_MASK_B;

  // Byte address of a register index; word step keeps the low two bits clear
  function automatic logic index_hit(input logic [13:0] addr, input logic [11:0] index);
    index_hit = (addr == {index, 2'b00});
  endfunction : index_hit

  // Register write with unimplemented bits held at zero
  function automatic tpio_pkg::tpio_port_t port_write(input tpio_pkg::tpio_port_t p,
                                                      input logic [3:0] idx,
                                                      input logic [15:0] wd,
                                                      input logic [15:0] msk,
                                                      input logic [15:0] amsk);
    tpio_pkg::tpio_port_t r;
    r = p;
    case (idx[2:0])
      3'h0: r.dir = wd & msk;
      3'h1: r.lat = wd & msk;
      3'h2: r.lat = wd & msk;
      3'h3: r.ods = wd & msk;
      3'h4: r.cne = wd & msk;
      3'h5: r.pu = wd & msk;
      3'h6: r.pd = wd & msk;
      3'h7: r.ans = wd & amsk;
      default: r = p;
    endcase
    port_write = r;
  endfunction : port_write

  // Register read view of one port
  function automatic logic [15:0] port_read(input tpio_pkg::tpio_port_t p, input logic [3:0] idx,
                                            input logic [15:0] lvl);
    case (idx[2:0])
      3'h0: port_read = p.dir;
      3'h1: port_read = lvl;
      3'h2: port_read = p.lat;
      3'h3: port_read = p.ods;
      3'h4: port_read = p.cne;
      3'h5: port_read = p.pu;
      3'h6: port_read = p.pd;
      3'h7: port_read = p.ans;
      default: port_read = 16'h0000;
    endcase
  endfunction : port_read

  logic [3:0] reg_idx;
  logic in_ports;
  logic is_stat;
  logic is_mask;
  logic access;
  logic [15:0] lvl_a;
  logic [15:0] lvl_b;
  logic [15:0] rd_word;
  logic [1:0] cn_event;
  logic commit;
  logic [15:0] hit_a;
  logic [15:0] hit_b;
  logic [15:0] pin_oe_a;
  logic [15:0] pin_oe_b;
  logic [15:0] pin_out_a;
  logic [15:0] pin_out_b;
  logic [15:0] pin_ana_a;
  logic [15:0] pin_ana_b;

  // Register map by index; byte address is four times the index
  //   E00 to E0E: port A direction, level, latch, open-drain, change enable,
  //               pull-up, pull-down, analog select
  //   E10 to E1E: the same eight registers for port B
  //   E20: change status, bit 0 port A, bit 1 port B; a read clears it
  //   E22: change mask, same layout
  //   Anything else reads zero and ignores writes, with no error
  assign reg_idx = PADDR[6:3];
  assign in_ports = (PADDR[13:7] == 7'h70) && (PADDR[2:0] == 3'h0);
  assign is_stat = index_hit(PADDR, `TPIO_OFF_IRQ_STAT);
  assign is_mask = index_hit(PADDR, `TPIO_OFF_IRQ_MASK);

  // First access edge raises ready and captures read data;
  // the write lands on the edge that sees ready, as the master expects
  assign access = PSEL && PENABLE && !s.pready;
  assign commit = PSEL && PENABLE && s.pready;

  // Per-pin level view and change hits from synchronised pins, so readback lags writes
  generate
    for (genvar k = 0; k < 16; k++) begin : g_sense
      if (msk_a[k]) begin : g_a_used
        assign lvl_a[k] = s.sync2_a[k] & ~(s.a.ans[k] & s.a.dir[k]);
        assign hit_a[k] = (s.sync2_a[k] ^ s.prev_a[k]) & s.a.cne[k];
      end else begin : g_a_none
        assign lvl_a[k] = 1'b0;
        assign hit_a[k] = 1'b0;
      end
      if (msk_b[k]) begin : g_b_used
        assign lvl_b[k] = s.sync2_b[k] & ~(s.b.ans[k] & s.b.dir[k]);
        assign hit_b[k] = (s.sync2_b[k] ^ s.prev_b[k]) & s.b.cne[k];
      end else begin : g_b_none
        assign lvl_b[k] = 1'b0;
        assign hit_b[k] = 1'b0;
      end
    end
  endgenerate

  // One flag per port: any enabled pin that moved since the last edge
  assign cn_event[0] = |hit_a;
  assign cn_event[1] = |hit_b;

  // Per-pin drive from the stored settings; pins follow a write one edge later
  generate
    for (genvar k = 0; k < 16; k++) begin : g_drive
      if (msk_a[k]) begin : g_a_used
        // Open-drain pins release instead of driving high
        assign pin_oe_a[k] = ~s.a.dir[k] & ~(s.a.ods[k] & s.a.lat[k]);
        assign pin_out_a[k] = s.a.lat[k] & ~s.a.ods[k];
      end else begin : g_a_none
        assign pin_oe_a[k] = 1'b0;
        assign pin_out_a[k] = 1'b0;
      end
      if (msk_b[k]) begin : g_b_used
        assign pin_oe_b[k] = ~s.b.dir[k] & ~(s.b.ods[k] & s.b.lat[k]);
        assign pin_out_b[k] = s.b.lat[k] & ~s.b.ods[k];
      end else begin : g_b_none
        assign pin_oe_b[k] = 1'b0;
        assign pin_out_b[k] = 1'b0;
      end
      // Analog path only where a select bit exists
      if (amsk_a[k]) begin : g_aa_used
        assign pin_ana_a[k] = s.a.ans[k];
      end else begin : g_aa_none
        assign pin_ana_a[k] = 1'b0;
      end
      if (amsk_b[k]) begin : g_ab_used
        assign pin_ana_b[k] = s.b.ans[k];
      end else begin : g_ab_none
        assign pin_ana_b[k] = 1'b0;
      end
    end
  endgenerate

  // Read data mux
  always_comb begin
    rd_word = 16'h0000;
    if (in_ports) begin
      if (reg_idx[3]) begin
        rd_word = port_read(s.b, reg_idx, lvl_b);
      end else begin
        rd_word = port_read(s.a, reg_idx, lvl_a);
      end
    end else if (is_stat) begin
      rd_word = {14'h0000, s.stat};
    end else if (is_mask) begin
      rd_word = {14'h0000, s.mask};
    end
  end

  // Next-state logic for everything
  always_comb begin
    next_s = s;
    next_s.sync1_a = {11'h000, PORT_A_IN};
    next_s.sync2_a = s.sync1_a;
    next_s.prev_a = s.sync2_a;
    next_s.sync1_b = PORT_B_IN;
    next_s.sync2_b = s.sync1_b;
    next_s.prev_b = s.sync2_b;
    next_s.pready = access;
    next_s.prdata = s.prdata;
    // Register writes land on the edge after the answer is raised
    if (commit && PWRITE) begin
      if (in_ports && reg_idx[3]) begin
        next_s.b = port_write(s.b, reg_idx, PWDATA[15:0], `TPIO_MASK_B, `TPIO_ANS_MASK_B);
      end else if (in_ports) begin
        next_s.a = port_write(s.a, reg_idx, PWDATA[15:0], `TPIO_MASK_A, `TPIO_ANS_MASK_A);
      end else if (is_mask) begin
        next_s.mask = PWDATA[1:0];
      end
    end
    if (access && !PWRITE) begin
      next_s.prdata = {16'h0000, rd_word};
      // Read of status clears it; a same-cycle event still lands
      if (is_stat) begin
        next_s.stat = 2'b00;
      end
    end
    next_s.stat = next_s.stat | cn_event;
    next_s.irq = |(next_s.stat & next_s.mask);
    // Pin drive registered from the per-pin logic
    next_s.a_oe = pin_oe_a;
    next_s.b_oe = pin_oe_b;
    next_s.a_out = pin_out_a;
    next_s.b_out = pin_out_b;
    // Analog path gated by select bit only
    next_s.ana_a = pin_ana_a;
    next_s.ana_b = pin_ana_b;
  end

  // State register; latch B resets to zero although software sees it as undefined
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      // Clear everything, then set each port configuration field explicitly
      s <= '0;
      s.a.dir <= `TPIO_RST_DIR_A;
      s.a.lat <= `TPIO_RST_ZERO;
      s.a.ods <= `TPIO_RST_ZERO;
      s.a.cne <= `TPIO_RST_ZERO;
      s.a.pu <= `TPIO_RST_ZERO;
      s.a.pd <= `TPIO_RST_ZERO;
      s.a.ans <= `TPIO_RST_ANS_A;
      s.b.dir <= `TPIO_RST_DIR_B;
      // Zero here so no pin starts from an unknown latch
      s.b.lat <= `TPIO_RST_ZERO;
      s.b.ods <= `TPIO_RST_ZERO;
      s.b.cne <= `TPIO_RST_ZERO;
      s.b.pu <= `TPIO_RST_ZERO;
      s.b.pd <= `TPIO_RST_ZERO;
      s.b.ans <= `TPIO_RST_ANS_B;
      // Analog paths come up selected, matching the select bits
      s.ana_a <= `TPIO_RST_ANS_A;
      s.ana_b <= `TPIO_RST_ANS_B;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops; PSLVERR tied low
  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = 1'b0;
  // Port A pins: only the five implemented bits leave the block
  assign PORT_A_OUT = s.a_out[4:0];
  assign PORT_A_OE = s.a_oe[4:0];
  assign PORT_A_PULLUP = s.a.pu[4:0];
  assign PORT_A_PULLDOWN = s.a.pd[4:0];
  assign PORT_A_ANALOG = s.ana_a[4:0];
  // Port B pins: all sixteen implemented
  assign PORT_B_OUT = s.b_out;
  assign PORT_B_OE = s.b_oe;
  assign PORT_B_PULLUP = s.b.pu;
  assign PORT_B_PULLDOWN = s.b.pd;
  assign PORT_B_ANALOG = s.ana_b;
  assign CHANGE_IRQ = s.irq;

endmodule : tpio_top

// [bench/tpio_properties.sv]
// Port-level checker for the two-port pin block
`timescale 1ns/10ps
module tpio_properties (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic [4:0] PORT_A_ANALOG,
  input wire logic [15:0] PORT_B_ANALOG,
  input wire logic CHANGE_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Bus answer timing and read data hold
  chk_ready_time: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("late");
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready stuck");
  chk_data_hold: assert property (!PREADY |-> $stable(PRDATA)) else $error("data moved");
  chk_upper_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
    else $error("upper bits set");
  // Analog paths come up enabled and exist only where implemented
  chk_rst_analog: assert property ($fell(RST) |-> PORT_B_ANALOG == 16'h06FF && PORT_A_ANALOG == 5'h07)
    else $error("analog reset");
  chk_ans_a_impl: assert property (PORT_A_ANALOG[4:3] == 2'h0) else $error("analog A");
  chk_ans_b_impl: assert property ((PORT_B_ANALOG & 16'hF900) == 16'h0000)
    else $error("analog B");
  // Request drops only after a bus access
  chk_irq_clear: assert property ($fell(CHANGE_IRQ) |-> $past(PSEL) || $past(PSEL, 2))
    else $error("irq dropped");
endmodule : tpio_properties
bind tpio_top tpio_properties tpio_properties_inst (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PORT_A_ANALOG(PORT_A_ANALOG),
  .PORT_B_ANALOG(PORT_B_ANALOG), .CHANGE_IRQ(CHANGE_IRQ));

// [bench/tpio_pins.sv]
// Board model: external drivers on one port's pins
`timescale 1ns/10ps
module tpio_pins #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] pd,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] level
);
  // Strong board driver on released pins; the weak pulls never win against it
  assign level = (oe & out) | (~oe & ext_val);
endmodule : tpio_pins

// [bench/tb.sv]
// Self-checking bench for the two-port pin block
`timescale 1ns/10ps
module tb;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq;
  logic [4:0] ain, aout, aoe, apu, apd, aan, ea = 5'h00;
  logic [15:0] bin, bout, boe, bpu, bpd, ban, da, db, eb = 16'h0000;
  logic [15:0] m [0:17];
  logic [1:0] st = 2'h0;
  int seed = 12, fail_count = 0, cmp_count = 0, n;
  initial forever #2.5 mclk = ~mclk;
  tpio_top tpio_top_inst (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PORT_A_IN(ain), .PORT_A_OUT(aout), .PORT_A_OE(aoe),
    .PORT_A_PULLUP(apu), .PORT_A_PULLDOWN(apd), .PORT_A_ANALOG(aan), .PORT_B_IN(bin),
    .PORT_B_OUT(bout), .PORT_B_OE(boe), .PORT_B_PULLUP(bpu), .PORT_B_PULLDOWN(bpd),
    .PORT_B_ANALOG(ban), .CHANGE_IRQ(irq));
  tpio_pins #(.W(5)) pins_a (.clk(mclk), .out(aout), .oe(aoe), .pu(apu), .pd(apd),
    .ext_val(ea), .level(ain));
  tpio_pins #(.W(16)) pins_b (.clk(mclk), .out(bout), .oe(boe), .pu(bpu), .pd(bpd),
    .ext_val(eb), .level(bin));
  // Writable bits per register index; gaps hold nothing
  function automatic logic [15:0] wm(int i);
    if (i < 8) return (i == 7) ? 16'h0007 : 16'h001F;
    if (i < 16) return (i == 15) ? 16'h06FF : 16'hFFFF;
    return (i == 17) ? 16'h0003 : 16'h0000;
  endfunction : wm
  // Driven unless input or a released open-drain high
  function automatic logic [15:0] drv(int b);
    return ~m[b] & ~(m[b+3] & m[b+2]);
  endfunction : drv
  // Expected read value; analog inputs read low
  function automatic logic [15:0] ev(int i);
    logic [15:0] p;
    p = (drv(i-1) & m[i+1]) | (~drv(i-1) & (i == 1 ? {11'h0, ea} : eb));
    if (i == 1 || i == 9) return p & ~(m[i+6] & m[i-1]) & wm(i);
    if (i == 16) return {14'h0, st};
    return (i < 16 || i == 17) ? m[i] : 16'h0000;
  endfunction : ev
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // One transfer; held until the edge that sees the answer
  task automatic apb(input logic w, input int i, input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {12'hE00 + 12'(2 * i), 2'b00};
    pwdata <= {16'h0, d};
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      fail_count++;
      $display("CHECK FAILED %0t no bus answer", $time);
    end
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    if (w && i < 16) m[(i == 1 || i == 9) ? i + 1 : i] = d & wm(i);
    if (w && i == 17) m[17] = d & wm(17);
    if (!w) cmp(r, {16'h0, ev(i)});
    if (!w && i == 16) st = 2'h0;
  endtask : apb
  // Pin outputs against the model after settling
  task automatic pins();
    repeat (4) @(posedge mclk);
    da = drv(0);
    db = drv(8);
    cmp({aoe, boe, aout & aoe}, {da[4:0], db, da[4:0] & m[2][4:0]});
    cmp({bout & boe, ban}, {db & m[10], m[15]});
    cmp({apu, apd, bpu}, {m[5][4:0], m[6][4:0], m[13]});
    cmp({bpd, 11'h0, aan}, {m[14], m[7]});
  endtask : pins
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    for (int i = 0; i < 18; i++) m[i] = 16'h0000;
    m[0] = 16'h001F;
    m[7] = 16'h0007;
    m[8] = 16'hFFFF;
    m[15] = 16'h06FF;
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    for (int i = 0; i < 19; i++) apb(0, i, 0);
    pins();
    $display("test reset done");
    // Random setup; change enables left off, unmapped place included
    for (int i = 0; i < 19; i++) if (i != 4 && i != 12 && i != 16) apb(1, i, 16'($random(seed)));
    ea <= 5'($random(seed));
    eb <= 16'($random(seed));
    pins();
    for (int i = 0; i < 19; i++) apb(0, i, 0);
    $display("test random done");
    // Outputs on analog pins, some open-drain, latch written through level
    apb(1, 15, 16'h06FF);
    apb(1, 8, 16'hFF00);
    apb(1, 11, 16'h00F0);
    apb(1, 9, 16'hA5A5);
    eb <= 16'hFFFF;
    pins();
    for (int i = 8; i < 16; i++) apb(0, i, 0);
    $display("test analog done");
    // Change request held by mask, raised, then cleared by reading status
    apb(1, 0, 16'h001F);
    apb(1, 8, 16'hFFFF);
    apb(1, 15, 16'h0000);
    apb(1, 4, 16'h0008);
    apb(1, 12, 16'h0001);
    apb(1, 17, 16'h0000);
    repeat (6) @(posedge mclk);
    ea[3] <= ~ea[3];
    eb[0] <= ~eb[0];
    st = 2'h3;
    repeat (8) @(posedge mclk);
    cmp(irq, 1'h0);
    apb(1, 17, 16'h0003);
    n = 0;
    while (irq !== 1'h1 && n < 20) begin @(posedge mclk); n++; end
    cmp(irq, 1'h1);
    apb(0, 16, 0);
    repeat (3) @(posedge mclk);
    cmp(irq, 1'h0);
    $display("test irq done");
    conclude();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule : tb
